/* hdl/pes_bank.sv */
// PCS extended status, jitter diagnostic and ten-bit interface control bank.
//
// Contract
// - Extended status read-only, bit 15 reads one.
// - Extended status bit 14 reads zero.
// - Bit 13 one, bit 12 zero, rest zero.
// - Diagnostic enable replaces traffic with test pattern.
// - Select field picks custom, random or reserved.
// - High and low frequency patterns are provided.
// - Custom field is the transmitted custom group.
// - Soft reset holds functional logic until cleared.
// - Shortcut makes both timers expire after 64.
// - Normal timers: 200000 and 1250000 cycles.
// - Receive disparity disable turns off receive checking.
// - Transmit disparity disable turns off transmit disparity.
// - Link timer value bit picks 1.6ms or 10ms.
// - Sense on: bypass partner completes without page.
// - Sense off: non-negotiating partner keeps link down.
// - Speed field selects port speed, resets 1000.
`timescale 1ns/100ps

module pes_bank #(
   parameter int LINK_SHORT_CYC = pes_pkg::LINK_SHORT_CYC,
   parameter int LINK_LONG_CYC = pes_pkg::LINK_LONG_CYC,
   parameter int SYNC_FAIL_CYC = pes_pkg::SYNC_FAIL_CYC
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   // Management register port, fed by the serial management decoder.
   input wire logic [4:0] mgmt_addr,
   input wire logic mgmt_wr,
   input wire logic mgmt_rd,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata_q,
   output logic mgmt_rvalid_q,
   // Transmit path: normal code groups in, code groups to the serializer.
   input wire logic [9:0] tx_code_in,
   output logic [9:0] tx_code_group_q,
   output logic diag_active_q,
   // Controls toward the functional modules.
   output logic func_reset_q,
   output logic rx_disp_disable_q,
   output logic tx_disp_disable_q,
   output logic [1:0] port_speed_select_q,
   // Timer bank: restart pulses in, expiry levels out.
   input wire logic link_timer_start,
   input wire logic sync_timer_start,
   output logic link_timer_done_q,
   output logic sync_timer_done_q,
   // Auto-negotiation result shaping.
   input wire logic an_done_in,
   input wire logic an_page_in,
   input wire logic an_bypass_partner,
   output logic an_complete_q,
   output logic an_page_rx_q
);

   // Stored register contents.
   pes_pkg::pes_jitter_t jit_q, jit_d;
   pes_pkg::pes_tbi_ctrl_t tbi_q, tbi_d;
   logic [15:0] rdata_d;
   logic rvalid_d;

   // Register write and read decode. Reserved bits are masked on write so
   // they can never hold a one and always read back as zero.
   always_comb begin
      jit_d = jit_q;
      tbi_d = tbi_q;
      rdata_d = mgmt_rdata_q;
      rvalid_d = 1'b0;
      if (mgmt_wr) begin
         if (mgmt_addr == pes_pkg::ADDR_JITTER) begin
            jit_d = mgmt_wdata & pes_pkg::JITTER_WMASK;
         end else if (mgmt_addr == pes_pkg::ADDR_TBI_CTRL) begin
            tbi_d = mgmt_wdata & pes_pkg::TBI_WMASK;
         end
         // A write to the status address or elsewhere is dropped.
      end
      if (mgmt_rd) begin
         rvalid_d = 1'b1;
         if (mgmt_addr == pes_pkg::ADDR_EXT_STATUS) begin
            rdata_d = pes_pkg::EXT_STATUS_VALUE;
         end else if (mgmt_addr == pes_pkg::ADDR_JITTER) begin
            rdata_d = jit_q;
         end else if (mgmt_addr == pes_pkg::ADDR_TBI_CTRL) begin
            rdata_d = tbi_q;
         end else begin
            rdata_d = 16'h0000;
         end
      end
   end

   // Register file flops; the clock enable freezes everything.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         jit_q <= pes_pkg::JITTER_RESET;
         tbi_q <= pes_pkg::TBI_RESET;
         mgmt_rdata_q <= 16'h0000;
         mgmt_rvalid_q <= 1'b0;
      end else if (clk_en) begin
         jit_q <= jit_d;
         tbi_q <= tbi_d;
         mgmt_rdata_q <= rdata_d;
         mgmt_rvalid_q <= rvalid_d;
      end
   end

   // Control outputs mirror the register one cycle later. Software owns
   // keeping the disparity bits low; the block obeys whatever is written.
   logic func_reset_d, rx_dis_d, tx_dis_d;
   logic [1:0] speed_d;

   always_comb begin
      func_reset_d = tbi_q.soft_rst;
      rx_dis_d = tbi_q.rx_disp_dis;
      tx_dis_d = tbi_q.tx_disp_dis;
      speed_d = tbi_q.speed;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         func_reset_q <= 1'b0;
         rx_disp_disable_q <= 1'b0;
         tx_disp_disable_q <= 1'b0;
         port_speed_select_q <= pes_pkg::SPEED_RESET;
      end else if (clk_en) begin
         func_reset_q <= func_reset_d;
         rx_disp_disable_q <= rx_dis_d;
         tx_disp_disable_q <= tx_dis_d;
         port_speed_select_q <= speed_d;
      end
   end

   // Random pattern source: a Galois shift register stepped every cycle.
   // It is cheap and never sticks at zero because the seed is non-zero.
   logic [15:0] lfsr_q, lfsr_d;
   logic [9:0] tx_d;
   logic diag_d;

   // Pattern mux. Reserved selects fall back to normal traffic, which is
   // safer on the line than sending an undefined code group.
   always_comb begin
      lfsr_d = {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? pes_pkg::LFSR_TAPS
                                                 : 16'h0000);
      tx_d = tx_code_in;
      diag_d = 1'b0;
      if (jit_q.en && !tbi_q.soft_rst) begin
         diag_d = 1'b1;
         case (jit_q.sel)
            pes_pkg::SEL_CUSTOM: begin
               tx_d = jit_q.custom;
            end
            pes_pkg::SEL_HIGH_FREQ: begin
               tx_d = pes_pkg::PAT_HIGH_FREQ;
            end
            pes_pkg::SEL_LOW_FREQ_A,
            pes_pkg::SEL_LOW_FREQ_B,
            pes_pkg::SEL_LOW_FREQ_C: begin
               tx_d = pes_pkg::PAT_LOW_FREQ;
            end
            pes_pkg::SEL_RANDOM: begin
               tx_d = lfsr_q[9:0];
            end
            default: begin
               tx_d = tx_code_in;
               diag_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         lfsr_q <= pes_pkg::LFSR_SEED;
         tx_code_group_q <= 10'h000;
         diag_active_q <= 1'b0;
      end else if (clk_en) begin
         lfsr_q <= lfsr_d;
         tx_code_group_q <= tx_d;
         diag_active_q <= diag_d;
      end
   end

   // Timer bank: entry 0 is the link timer, entry 1 the sync fail timer.
   logic [pes_pkg::TMR_NUM-1:0] tmr_start;
   logic [pes_pkg::TMR_NUM-1:0] tmr_done;
   logic [pes_pkg::TMR_W-1:0] link_limit;
   logic [pes_pkg::TMR_W-1:0] sync_limit;
   logic [pes_pkg::TMR_W-1:0] link_cnt_seen;

   // Expiry counts; the shortcut wins over the value control bit.
   always_comb begin
      tmr_start[pes_pkg::TMR_LINK] = link_timer_start;
      tmr_start[pes_pkg::TMR_SYNC] = sync_timer_start;
      if (tbi_q.shortcut) begin
         link_limit = pes_pkg::TMR_W'(pes_pkg::SHORTCUT_CYC);
         sync_limit = pes_pkg::TMR_W'(pes_pkg::SHORTCUT_CYC);
      end else begin
         link_limit = tbi_q.link_long ? pes_pkg::TMR_W'(LINK_LONG_CYC)
                                      : pes_pkg::TMR_W'(LINK_SHORT_CYC);
         sync_limit = pes_pkg::TMR_W'(SYNC_FAIL_CYC);
      end
   end

   // Each timer counts from its start pulse and latches done when the
   // count reaches the limit; soft reset clears it like a restart.
   for (genvar i = 0; i < pes_pkg::TMR_NUM; i++) begin : g_tmr
      logic [pes_pkg::TMR_W-1:0] cnt_q, cnt_d, lim;
      logic done_q, done_d;

      always_comb begin
         lim = (i == pes_pkg::TMR_LINK) ? link_limit : sync_limit;
         cnt_d = cnt_q;
         done_d = done_q;
         if (tmr_start[i] || tbi_q.soft_rst) begin
            cnt_d = '0;
            done_d = 1'b0;
         end else if (!done_q) begin
            cnt_d = cnt_q + 1'b1;
            done_d = (cnt_q + 1'b1) >= lim;
         end
      end

      always_ff @(posedge clock) begin
         if (!reset_n) begin
            cnt_q <= '0;
            done_q <= 1'b0;
         end else if (clk_en) begin
            cnt_q <= cnt_d;
            done_q <= done_d;
         end
      end

      assign tmr_done[i] = done_q;
   end

   assign link_cnt_seen = g_tmr[pes_pkg::TMR_LINK].cnt_q;

   always_comb begin
      link_timer_done_q = tmr_done[pes_pkg::TMR_LINK];
      sync_timer_done_q = tmr_done[pes_pkg::TMR_SYNC];
   end

   // Auto-negotiation result. With sense on, a bypass partner completes
   // the link with no page; with sense off it is ignored, link stays down.
   logic an_complete_d, an_page_d, sensed;

   always_comb begin
      sensed = tbi_q.an_sense && an_bypass_partner && !an_done_in;
      an_complete_d = an_done_in || sensed;
      an_page_d = an_page_in && !sensed;
      if (tbi_q.soft_rst) begin
         an_complete_d = 1'b0;
         an_page_d = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         an_complete_q <= 1'b0;
         an_page_rx_q <= 1'b0;
      end else if (clk_en) begin
         an_complete_q <= an_complete_d;
         an_page_rx_q <= an_page_d;
      end
   end

   // Checks placed beside the logic above.
   sequence s_status_read;
      clk_en && mgmt_rd && mgmt_addr == pes_pkg::ADDR_EXT_STATUS;
   endsequence

   a_ext_status_value: assert property (
      @(posedge clock) disable iff (!reset_n)
      s_status_read |=> mgmt_rdata_q[15] && !mgmt_rdata_q[14] && mgmt_rvalid_q)
      else $error("extended status bit 15 or 14 wrong");
   a_ext_status_low: assert property (
      @(posedge clock) disable iff (!reset_n)
      s_status_read |=> mgmt_rdata_q[13:0] == 14'h2000)
      else $error("extended status low bits wrong");
   a_reserved_jitter: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en && mgmt_rd && mgmt_addr == pes_pkg::ADDR_JITTER
      |=> mgmt_rdata_q[11:10] == 2'h0)
      else $error("reserved jitter bits read back non-zero");
   a_diag_custom: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en && jit_q.en && !tbi_q.soft_rst && jit_q.sel == 3'h0
      |=> tx_code_group_q == $past(jit_q.custom) && diag_active_q)
      else $error("custom pattern not transmitted");
   // The sampled reset term keeps out the release edge, which still resets.
   a_diag_normal: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en && reset_n && !jit_q.en |=> tx_code_group_q == $past(tx_code_in)
      && !diag_active_q)
      else $error("normal traffic not passed through");
   a_high_freq: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en && jit_q.en && !tbi_q.soft_rst && jit_q.sel == 3'h1
      |=> tx_code_group_q == 10'h2AA)
      else $error("high frequency pattern wrong");
   a_link_expiry: assert property (
      @(posedge clock) disable iff (!reset_n)
      $rose(link_timer_done_q) |->
      $past(link_cnt_seen) + 1'b1 == $past(link_limit))
      else $error("link timer expired at the wrong count");
   a_shortcut_limit: assert property (
      @(posedge clock) disable iff (!reset_n)
      tbi_q.shortcut |-> link_limit == 21'd64 && sync_limit == 21'd64)
      else $error("shortcut limit is not 64 cycles");
   a_speed_reset: assert property (
      @(posedge clock)
      !reset_n |=> port_speed_select_q == 2'h2)
      else $error("speed field did not reset to 1000 Mbps");
   a_soft_reset: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en && tbi_q.soft_rst |=>
      func_reset_q && !link_timer_done_q && !sync_timer_done_q)
      else $error("soft reset did not hold the functions");
   a_an_sense: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en && tbi_q.an_sense && !tbi_q.soft_rst && an_bypass_partner
      |=> an_complete_q && ($past(an_done_in) || !an_page_rx_q))
      else $error("sensed partner not reported complete");
   a_an_strict: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en && !tbi_q.an_sense && !an_done_in |=> !an_complete_q)
      else $error("link came up without negotiation");
   a_disparity: assert property (
      @(posedge clock) disable iff (!reset_n)
      clk_en |=> tx_disp_disable_q == $past(tbi_q.tx_disp_dis)
      && rx_disp_disable_q == $past(tbi_q.rx_disp_dis))
      else $error("disparity disable outputs do not follow control");
endmodule

/* hdl/pes_pkg.sv */
// Package with register map, field layouts and timing for the PCS bank.
package pes_pkg;

   // Register addresses on the management register port.
   localparam logic [4:0] ADDR_EXT_STATUS = 5'h0F;
   localparam logic [4:0] ADDR_JITTER = 5'h10;
   localparam logic [4:0] ADDR_TBI_CTRL = 5'h11;

   // Extended status: 1000BASE-X FD and 1000BASE-T FD set, rest zero.
   localparam logic [15:0] EXT_STATUS_VALUE = 16'hA000;

   // Writable bits of the two control registers; the rest read as zero.
   localparam logic [15:0] JITTER_WMASK = 16'hF3FF;
   localparam logic [15:0] TBI_WMASK = 16'hF90C;

   // Reset values: jitter all zero, speed field at 1000 Mbps.
   localparam logic [15:0] JITTER_RESET = 16'h0000;
   localparam logic [15:0] TBI_RESET = 16'h0008;
   localparam logic [1:0] SPEED_RESET = 2'h2;

   // Jitter diagnostic register layout, bit 15 down to bit 0.
   typedef struct packed {
      logic en;
      logic [2:0] sel;
      logic [1:0] rsv;
      logic [9:0] custom;
   } pes_jitter_t;

   // Ten-bit interface control register layout, bit 15 down to bit 0.
   typedef struct packed {
      logic soft_rst;
      logic shortcut;
      logic rx_disp_dis;
      logic tx_disp_dis;
      logic link_long;
      logic [1:0] rsv_hi;
      logic an_sense;
      logic [3:0] rsv_mid;
      logic [1:0] speed;
      logic [1:0] rsv_lo;
   } pes_tbi_ctrl_t;

   // Pattern select encodings.
   localparam logic [2:0] SEL_CUSTOM = 3'h0;
   localparam logic [2:0] SEL_HIGH_FREQ = 3'h1;
   localparam logic [2:0] SEL_LOW_FREQ_A = 3'h2;
   localparam logic [2:0] SEL_LOW_FREQ_B = 3'h3;
   localparam logic [2:0] SEL_RANDOM = 3'h4;
   localparam logic [2:0] SEL_LOW_FREQ_C = 3'h5;

   // Fixed diagnostic code groups.
   localparam logic [9:0] PAT_HIGH_FREQ = 10'h2AA;
   localparam logic [9:0] PAT_LOW_FREQ = 10'h3E0;

   // Random pattern generator seed and feedback taps.
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;

   // Timer figures in their own units and derived cycle counts.
   localparam int CLK_PERIOD_NS = 8;
   localparam int LINK_SHORT_NS = 1600000;
   localparam int LINK_LONG_NS = 10000000;
   localparam int LINK_SHORT_CYC = LINK_SHORT_NS / CLK_PERIOD_NS;
   localparam int LINK_LONG_CYC = LINK_LONG_NS / CLK_PERIOD_NS;
   localparam int SYNC_FAIL_CYC = 1250000;
   localparam int SHORTCUT_CYC = 64;
   localparam int TMR_W = 21;

   // Timer indices inside the timer bank.
   localparam int TMR_LINK = 0;
   localparam int TMR_SYNC = 1;
   localparam int TMR_NUM = 2;

endpackage

/* sim/pes_bank_tb.sv */
// Self-checking testbench for the PCS register bank.
`timescale 1ns/100ps
module pes_bank_tb;
   // Design inputs owned by the bench.
   logic clock, reset_n, clk_en, link_timer_start, sync_timer_start;
   logic an_done_in, an_page_in, an_bypass_partner;
   logic [9:0] tx_code_in;
   // Register port and design outputs.
   logic [4:0] mgmt_addr;
   logic mgmt_wr, mgmt_rd, mgmt_rvalid_q, diag_active_q, func_reset_q;
   logic [15:0] mgmt_wdata, mgmt_rdata_q;
   logic [9:0] tx_code_group_q, e;
   logic rx_disp_disable_q, tx_disp_disable_q, link_timer_done_q;
   logic sync_timer_done_q, an_complete_q, an_page_rx_q;
   logic [1:0] port_speed_select_q;
   int miscompares, cmp_count, i;
   // Small timer limits keep the run short; all are above the shortcut.
   pes_bank #(.LINK_SHORT_CYC(100), .LINK_LONG_CYC(200),
      .SYNC_FAIL_CYC(300)) u_dut (.clock(clock), .reset_n(reset_n),
      .clk_en(clk_en), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr),
      .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q),
      .tx_code_in(tx_code_in), .tx_code_group_q(tx_code_group_q),
      .diag_active_q(diag_active_q), .func_reset_q(func_reset_q),
      .rx_disp_disable_q(rx_disp_disable_q),
      .tx_disp_disable_q(tx_disp_disable_q),
      .port_speed_select_q(port_speed_select_q),
      .link_timer_start(link_timer_start),
      .sync_timer_start(sync_timer_start),
      .link_timer_done_q(link_timer_done_q),
      .sync_timer_done_q(sync_timer_done_q), .an_done_in(an_done_in),
      .an_page_in(an_page_in), .an_bypass_partner(an_bypass_partner),
      .an_complete_q(an_complete_q), .an_page_rx_q(an_page_rx_q));
   // The management partner owns the strobe port.
   pes_sta_model u_sta (.clock(clock), .mgmt_addr(mgmt_addr),
      .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
      .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q));
   // Free-running 125 MHz clock.
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Case-equal compare; narrower values arrive zero extended.
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Read through the partner and compare; a lost answer ends the run.
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      logic ok;
      u_sta.read_reg(a, d, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: no read answer", $time);
         close_out();
      end
      check(d, exp);
   endtask
   // Let n edges pass and sample once their updates have landed.
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Pulses one timer start and counts enabled cycles until expiry.
   task automatic time_it(input logic link, input int exp);
      int n;
      @(posedge clock);
      link_timer_start <= link;
      sync_timer_start <= ~link;
      @(posedge clock);
      link_timer_start <= 1'b0;
      sync_timer_start <= 1'b0;
      for (n = 0; n < 400; n++) begin
         #1;
         if ((link ? link_timer_done_q : sync_timer_done_q) === 1'b1) begin
            break;
         end
         @(posedge clock);
      end
      if (n == 400) begin
         miscompares++;
         $display("mismatch at %0t: timer never expired", $time);
         close_out();
      end
      check(16'(n), 16'(exp));
   endtask
   // Main sequence: reset, then one test after another.
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      tx_code_in = 10'h1C3;
      link_timer_start = 1'b0;
      sync_timer_start = 1'b0;
      an_done_in = 1'b0;
      an_page_in = 1'b1;
      an_bypass_partner = 1'b1;
      miscompares = 0;
      cmp_count = 0;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      step(0);
      check(16'(port_speed_select_q), 16'h0002);
      rd_chk(pes_pkg::ADDR_EXT_STATUS, 16'hA000);
      rd_chk(pes_pkg::ADDR_JITTER, 16'h0000);
      rd_chk(pes_pkg::ADDR_TBI_CTRL, 16'h0008);
      $display("test reset_values done");
      // Read-only status, reserved bits and an unmapped place.
      u_sta.write_reg(pes_pkg::ADDR_EXT_STATUS, 16'hFFFF);
      rd_chk(pes_pkg::ADDR_EXT_STATUS, 16'hA000);
      u_sta.write_reg(pes_pkg::ADDR_JITTER, 16'hFFFF);
      rd_chk(pes_pkg::ADDR_JITTER, 16'hF3FF);
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'hFFFF);
      rd_chk(pes_pkg::ADDR_TBI_CTRL, 16'hF90C);
      rd_chk(5'h05, 16'h0000);
      $display("test access_kinds done");
      // Soft reset with diagnostics on holds traffic normal until cleared.
      u_sta.write_reg(pes_pkg::ADDR_JITTER, 16'h8155);
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h8008);
      step(1);
      check(16'(func_reset_q), 16'h0001);
      check(16'(diag_active_q), 16'h0000);
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h0008);
      step(1);
      check(16'(func_reset_q), 16'h0000);
      $display("test soft_reset done");
      // Every select code with diagnostics on, then normal traffic again.
      for (i = 0; i < 8; i++) begin
         u_sta.write_reg(pes_pkg::ADDR_JITTER, {1'b1, 3'(i), 12'h155});
         step(1);
         case (i)
            0: e = 10'h155;
            1: e = 10'h2AA;
            2, 3, 5: e = 10'h3E0;
            default: e = tx_code_in;
         endcase
         check(16'(diag_active_q), 16'(i < 6));
         if (i != 4) begin
            check(16'(tx_code_group_q), 16'(e));
         end
      end
      u_sta.write_reg(pes_pkg::ADDR_JITTER, 16'h0155);
      step(1);
      check(16'(tx_code_group_q), 16'(tx_code_in));
      $display("test patterns done");
      // Disparity disables and a speed change reach the outputs.
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h3004);
      step(1);
      check(16'(rx_disp_disable_q), 16'h0001);
      check(16'(tx_disp_disable_q), 16'h0001);
      check(16'(port_speed_select_q), 16'h0001);
      $display("test controls done");
      // Timer lengths with shortcut, short and long link values.
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h4008);
      time_it(1'b1, 64);
      time_it(1'b0, 64);
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h0008);
      time_it(1'b1, 100);
      time_it(1'b0, 300);
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h0808);
      time_it(1'b1, 200);
      $display("test timers done");
      // A non-negotiating partner with sense off and then on.
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h0008);
      step(1);
      check(16'(an_complete_q), 16'h0000);
      u_sta.write_reg(pes_pkg::ADDR_TBI_CTRL, 16'h0108);
      step(1);
      check(16'(an_complete_q), 16'h0001);
      check(16'(an_page_rx_q), 16'h0000);
      $display("test auto_neg_sense done");
      // With the clock enable low a write strobe is not taken.
      @(posedge clock);
      clk_en <= 1'b0;
      u_sta.write_reg(pes_pkg::ADDR_JITTER, 16'h8000);
      @(posedge clock);
      clk_en <= 1'b1;
      rd_chk(pes_pkg::ADDR_JITTER, 16'h0155);
      check(16'(diag_active_q), 16'h0000);
      $display("test clock_enable done");
      // A reset in mid-run brings back the reset values of the bank.
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      step(0);
      check(16'(port_speed_select_q), 16'h0002);
      check(16'(an_complete_q), 16'h0000);
      rd_chk(pes_pkg::ADDR_TBI_CTRL, 16'h0008);
      rd_chk(pes_pkg::ADDR_JITTER, 16'h0000);
      $display("test mid_reset done");
      close_out();
   end
endmodule

/* sim/pes_sta_model.sv */
// Station management model that drives the bank's register strobe port.
`timescale 1ns/100ps
module pes_sta_model (
   input wire logic clock,
   output logic [4:0] mgmt_addr,
   output logic mgmt_wr,
   output logic mgmt_rd,
   output logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata_q,
   input wire logic mgmt_rvalid_q
);
   // Lines start quiet so nothing is requested before reset ends.
   initial begin
      mgmt_addr = 5'h00;
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      mgmt_wdata = 16'h0000;
   end
   // One write strobe; released lines show inverted values, so a design
   // that samples late cannot pick up stale data by accident.
   task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
      @(posedge clock);
      mgmt_addr <= a;
      mgmt_wdata <= d;
      mgmt_wr <= 1'b1;
      @(posedge clock);
      mgmt_wr <= 1'b0;
      mgmt_addr <= ~a;
      mgmt_wdata <= ~d;
   endtask
   // One read strobe, then a bounded wait for the valid pulse.
   task automatic read_reg(input logic [4:0] a, output logic [15:0] d,
                           output logic ok);
      int n;
      ok = 1'b0;
      d = 16'h0000;
      @(posedge clock);
      mgmt_addr <= a;
      mgmt_rd <= 1'b1;
      @(posedge clock);
      mgmt_rd <= 1'b0;
      mgmt_addr <= ~a;
      for (n = 0; n < 4; n++) begin
         #1;
         if (mgmt_rvalid_q === 1'b1) begin
            d = mgmt_rdata_q;
            ok = 1'b1;
            break;
         end
         @(posedge clock);
      end
   endtask
endmodule
